/* core/srbg_cfg.svh */
// register map, field positions, reset values and divide limits of the rate generator
// assumes a byte-wide register port with a 3-bit word index
`ifndef SRBG_CFG_SVH
`define SRBG_CFG_SVH

`define SRBG_OFS_RATE_CTL 3'h0
`define SRBG_OFS_RX_CTL 3'h1
`define SRBG_OFS_DIV_LOW 3'h2
`define SRBG_OFS_DIV_HIGH 3'h3
`define SRBG_OFS_TX_CTL 3'h4

`define SRBG_BIT_RX_IDLE 6
`define SRBG_BIT_WIDE 3
`define SRBG_BIT_CLK_POL 4
`define SRBG_BIT_CLK_MASTER 7
`define SRBG_BIT_SYNC 4
`define SRBG_BIT_FAST 2
`define SRBG_BIT_TX_EMPTY 1

`define SRBG_MASK_RATE_CTL 8'h1b
`define SRBG_MASK_RX_CTL 8'hf8
`define SRBG_MASK_TX_CTL 8'hfd

`define SRBG_RST_RATE_CTL 8'h00
`define SRBG_RST_RX_CTL 8'h00
`define SRBG_RST_TX_CTL 8'h00
`define SRBG_RST_DIV 8'h00

// prescale limits are half the multiplier minus one
`define SRBG_HALF_LIM_64 5'h1f
`define SRBG_HALF_LIM_16 5'h07
`define SRBG_HALF_LIM_4 5'h01
`define SRBG_MULT_64 7'h40
`define SRBG_MULT_16 7'h10
`define SRBG_MULT_4 7'h04

`endif

/* core/srbg_pkg.sv */
// types shared by the rate generator modules
// assumes nothing beyond the compile order header, package, modules
package srbg_pkg;

    typedef enum logic [1:0] {SRBG_DIV64, SRBG_DIV16, SRBG_DIV4} srbg_ratio_t;

    typedef logic [2:0] srbg_addr_t;

endpackage : srbg_pkg

/* core/srbg_prescale.sv */
// prescaler: pulses done once every limit+1 clocks
// assumes restart is a one-cycle pulse from the register side
module srbg_prescale
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic restart,
    input wire logic [4:0] limit,
    output logic done
);

    logic [4:0] count_q;
    logic [4:0] count_d;

    assign done = (count_q == 5'h00) && !restart;
    assign count_d = (restart || count_q == 5'h00) ? limit : count_q - 5'h01;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            count_q <= 5'h1f;
        else
            count_q <= count_d;
    end

endmodule : srbg_prescale

/* core/srbg_timer.sv */
// reloading down-counter; expires after n+1 prescaler steps
// assumes step and restart are one-cycle pulses
module srbg_timer
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic restart,
    input wire logic step,
    input wire logic [15:0] reload,
    output logic expire,
    output logic [15:0] count
);

    logic [15:0] count_q;
    logic [15:0] count_d;

    assign expire = step && (count_q == 16'h0000) && !restart;
    assign count = count_q;

    always_comb
    begin
        count_d = count_q;
        if (restart || expire)
            count_d = reload;
        else if (step)
            count_d = count_q - 16'h0001;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            count_q <= 16'h0000;
        else
            count_q <= count_d;
    end

endmodule : srbg_timer

/* core/srbg_core.sv */
// rate generator top: control registers, divisor pair and bit-rate ticks
// assumes a byte register port, read data one cycle after the read strobe
//
// Chosen here: the placing of the registers and strobed register access.
`include "srbg_cfg.svh"

// Contract
// RULE1: eight-bit counter after reset, wide when selected
// RULE2: timer runs freely, period from divisor pair
// RULE3: async ratio from speed and width; sync ignores speed
// RULE4: async narrow low speed divides by 64(n+1)
// RULE5: async wide low speed divides by 16(n+1)
// RULE6: sync divides by 4(n+1), either width
// RULE7: async fast: narrow 16(n+1), wide 4(n+1)
// RULE8: divisor write restarts the timer at once
// RULE9: software checks idle flag before clock change
// RULE10: high byte bits 15:8, low byte 7:0
// RULE11: software picks fast or wide to cut error
// RULE12: idle flag reads one when receiver idle
// RULE13: sync bit one selects synchronous operation
// RULE14: sync master drives clock from the generator
module srbg_core
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [2:0] addr,
    input wire logic [7:0] wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    output logic [7:0] rdData,
    input wire logic receiverIdle,
    input wire logic txShiftEmpty,
    output logic bitTick,
    output logic halfTick,
    output logic syncClkOut,
    output logic syncClkOe,
    output logic syncMode,
    output logic clockMaster
);

    function automatic logic isDivisor(input srbg_pkg::srbg_addr_t a);
        isDivisor = (a == `SRBG_OFS_DIV_LOW) || (a == `SRBG_OFS_DIV_HIGH);
    endfunction : isDivisor

    function automatic srbg_pkg::srbg_ratio_t ratioOf(input logic sync, input logic wide,
        input logic fast);
        if (sync)
            ratioOf = srbg_pkg::SRBG_DIV4; // see RULE6
        else if (wide && fast)
            ratioOf = srbg_pkg::SRBG_DIV4; // see RULE7
        else if (wide || fast)
            ratioOf = srbg_pkg::SRBG_DIV16; // see RULE5 RULE7
        else
            ratioOf = srbg_pkg::SRBG_DIV64; // see RULE4
    endfunction : ratioOf

    logic [7:0] rateCtl_q;
    logic [7:0] rxCtl_q;
    logic [7:0] txCtl_q;
    logic [7:0] divLow_q;
    logic [7:0] divHigh_q;
    logic restart_q;
    logic phase_q;
    logic [7:0] rdData_q;
    logic bitTick_q;
    logic halfTick_q;
    logic syncClk_q;
    logic syncClkOe_q;

    wire logic wrRate = wrStrobe && (addr == `SRBG_OFS_RATE_CTL);
    wire logic wrRx = wrStrobe && (addr == `SRBG_OFS_RX_CTL);
    wire logic wrTx = wrStrobe && (addr == `SRBG_OFS_TX_CTL);
    wire logic wrLow = wrStrobe && (addr == `SRBG_OFS_DIV_LOW);
    wire logic wrHigh = wrStrobe && (addr == `SRBG_OFS_DIV_HIGH);
    wire logic wrDiv = wrStrobe && isDivisor(addr);
    wire logic wideSel = rateCtl_q[`SRBG_BIT_WIDE];
    wire logic syncSel = txCtl_q[`SRBG_BIT_SYNC];
    wire logic fastSel = txCtl_q[`SRBG_BIT_FAST];
    wire logic masterSel = txCtl_q[`SRBG_BIT_CLK_MASTER];
    wire logic clkPol = rateCtl_q[`SRBG_BIT_CLK_POL];
    wire srbg_pkg::srbg_ratio_t ratio = ratioOf(syncSel, wideSel, fastSel); // see RULE3
    // narrow mode ignores the high byte
    wire logic [15:0] divisorN = wideSel ? {divHigh_q, divLow_q} : {8'h00, divLow_q}; // see RULE1
    wire logic [4:0] halfLimit = (ratio == srbg_pkg::SRBG_DIV64) ? `SRBG_HALF_LIM_64 :
        (ratio == srbg_pkg::SRBG_DIV16) ? `SRBG_HALF_LIM_16 : `SRBG_HALF_LIM_4;
    wire logic preDone;
    wire logic expire;
    wire logic [15:0] timerCount;
    wire logic syncMasterOn = syncSel && masterSel; // see RULE14
    wire logic [7:0] rateRead = (rateCtl_q & `SRBG_MASK_RATE_CTL)
        | (8'({receiverIdle}) << `SRBG_BIT_RX_IDLE); // see RULE12
    wire logic [7:0] txRead = (txCtl_q & `SRBG_MASK_TX_CTL)
        | (8'({txShiftEmpty}) << `SRBG_BIT_TX_EMPTY);
    wire logic [7:0] rdMux = (addr == `SRBG_OFS_RATE_CTL) ? rateRead :
        (addr == `SRBG_OFS_RX_CTL) ? (rxCtl_q & `SRBG_MASK_RX_CTL) :
        (addr == `SRBG_OFS_DIV_LOW) ? divLow_q :
        (addr == `SRBG_OFS_DIV_HIGH) ? divHigh_q :
        (addr == `SRBG_OFS_TX_CTL) ? txRead : 8'h00;

    // half-period steps: two per bit so the sync clock is symmetric
    srbg_prescale u_prescale
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .restart(restart_q),
        .limit(halfLimit),
        .done(preDone)
    );

    srbg_timer u_timer
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .restart(restart_q),
        .step(preDone),
        .reload(divisorN),
        .expire(expire),
        .count(timerCount)
    );

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            rateCtl_q <= `SRBG_RST_RATE_CTL;
            rxCtl_q <= `SRBG_RST_RX_CTL;
            txCtl_q <= `SRBG_RST_TX_CTL;
        end
        else
        begin
            if (wrRate)
                rateCtl_q <= wrData & `SRBG_MASK_RATE_CTL;
            if (wrRx)
                rxCtl_q <= wrData & `SRBG_MASK_RX_CTL;
            if (wrTx)
                txCtl_q <= wrData & `SRBG_MASK_TX_CTL;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            divLow_q <= `SRBG_RST_DIV;
            divHigh_q <= `SRBG_RST_DIV;
        end
        else
        begin
            if (wrLow)
                divLow_q <= wrData; // see RULE10
            if (wrHigh)
                divHigh_q <= wrData; // see RULE10
        end
    end

    // restart one cycle later so the new divisor is already stored
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            restart_q <= 1'b1;
        else
            restart_q <= wrDiv; // see RULE8
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst || restart_q)
            phase_q <= 1'b0;
        else if (expire)
            phase_q <= !phase_q; // see RULE2
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            bitTick_q <= 1'b0;
            halfTick_q <= 1'b0;
        end
        else
        begin
            halfTick_q <= expire;
            bitTick_q <= expire && phase_q; // see RULE2
        end
    end

    // idle level follows the polarity bit; edges at each half period
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            syncClk_q <= 1'b0;
            syncClkOe_q <= 1'b0;
        end
        else
        begin
            syncClkOe_q <= syncMasterOn; // see RULE14
            if (!syncMasterOn || restart_q)
                syncClk_q <= clkPol;
            else if (expire)
                syncClk_q <= !syncClk_q; // see RULE14
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            rdData_q <= 8'h00;
        else if (rdStrobe)
            rdData_q <= rdMux;
        else
            rdData_q <= 8'h00;
    end

    assign rdData = rdData_q;
    assign bitTick = bitTick_q;
    assign halfTick = halfTick_q;
    assign syncClkOut = syncClk_q;
    assign syncClkOe = syncClkOe_q;
    assign syncMode = txCtl_q[`SRBG_BIT_SYNC]; // see RULE13
    assign clockMaster = txCtl_q[`SRBG_BIT_CLK_MASTER];

    // checking helpers: cycles between bit ticks under steady settings
    logic [22:0] spanCnt_q;
    logic spanValid_q;
    logic [6:0] multNow;
    logic [22:0] spanExpect;

    assign multNow = (ratio == srbg_pkg::SRBG_DIV64) ? `SRBG_MULT_64 :
        (ratio == srbg_pkg::SRBG_DIV16) ? `SRBG_MULT_16 : `SRBG_MULT_4;
    assign spanExpect = 23'((32'(multNow) * (32'(divisorN) + 32'd1)) - 32'd1);

    always_ff @(posedge clk_sys)
    begin
        if (rst || bitTick_q)
            spanCnt_q <= 23'h000000;
        else
            spanCnt_q <= spanCnt_q + 23'h000001;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst || wrStrobe)
            spanValid_q <= 1'b0;
        else if (bitTick_q)
            spanValid_q <= 1'b1;
    end

    chk_narrow_after_reset: assert property (@(posedge clk_sys) // see RULE1
        rst |=> !wideSel && divisorN[15:8] == 8'h00)
        else $error("counter not narrow after reset");

    chk_ratio_narrow_slow: assert property (@(posedge clk_sys) disable iff (rst) // see RULE4
        bitTick_q && spanValid_q && !syncSel && !wideSel && !fastSel
        |-> spanCnt_q == 23'((32'd64 * (32'(divLow_q) + 32'd1)) - 32'd1))
        else $error("narrow slow async period wrong");

    chk_ratio_wide_slow: assert property (@(posedge clk_sys) disable iff (rst) // see RULE5
        bitTick_q && spanValid_q && !syncSel && wideSel && !fastSel
        |-> spanCnt_q == 23'((32'd16 * (32'({divHigh_q, divLow_q}) + 32'd1)) - 32'd1))
        else $error("wide slow async period wrong");

    chk_ratio_sync: assert property (@(posedge clk_sys) disable iff (rst) // see RULE6
        bitTick_q && spanValid_q && syncSel
        |-> spanCnt_q == 23'((32'd4 * (32'(divisorN) + 32'd1)) - 32'd1))
        else $error("sync period wrong");

    chk_ratio_fast: assert property (@(posedge clk_sys) disable iff (rst) // see RULE7
        bitTick_q && spanValid_q && !syncSel && fastSel |-> spanCnt_q == spanExpect
        && multNow == (wideSel ? 7'h04 : 7'h10))
        else $error("fast async period wrong");

    chk_sync_ignores_fast: assert property (@(posedge clk_sys) disable iff (rst) // see RULE3
        syncSel |-> ratio == srbg_pkg::SRBG_DIV4 && halfLimit == 5'h01)
        else $error("sync rate depends on speed bit");

    chk_free_running: assert property (@(posedge clk_sys) disable iff (rst) // see RULE2
        spanValid_q |-> spanCnt_q <= spanExpect)
        else $error("bit tick overdue");

    chk_divisor_write: assert property (@(posedge clk_sys) disable iff (rst) // see RULE8
        wrDiv ##1 !wrDiv |=> timerCount == divisorN && !halfTick_q)
        else $error("divisor write did not restart timer");

    chk_divisor_bytes: assert property (@(posedge clk_sys) disable iff (rst) // see RULE10
        wrHigh && !wrLow |=> divHigh_q == $past(wrData) && divLow_q == $past(divLow_q))
        else $error("divisor high byte not stored");

    chk_idle_flag: assert property (@(posedge clk_sys) disable iff (rst) // see RULE12
        rdStrobe && addr == `SRBG_OFS_RATE_CTL |=> rdData_q[6] == $past(receiverIdle))
        else $error("idle flag read wrong");

    chk_clock_master: assert property (@(posedge clk_sys) disable iff (rst) // see RULE14
        syncClkOe_q && $past(syncClkOe_q) && !$past(restart_q) && halfTick_q
        |-> syncClk_q != $past(syncClk_q))
        else $error("master clock did not toggle");

    chk_mode_select: assert property (@(posedge clk_sys) disable iff (rst) // see RULE13
        wrTx |=> syncMode == $past(wrData[4]))
        else $error("sync select not stored");

endmodule : srbg_core

/* test/srbg_serial_partner.sv */
// partner model: receiver frame timing and transmit shift status of the port
// assumes one bitTick per bit period from the rate generator
module srbg_serial_partner
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic bitTick,
    input wire logic startRx,
    input wire logic txLoad,
    output logic receiverIdle,
    output logic txShiftEmpty
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] bitsLeft_q;

    // a frame of ten bits after a start bit
    assign receiverIdle = (bitsLeft_q == 4'h0);
    assign txShiftEmpty = ~txLoad;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            bitsLeft_q <= 4'h0;
        else if (startRx)
            bitsLeft_q <= 4'ha;
        else if (bitTick && bitsLeft_q != 4'h0)
            bitsLeft_q <= bitsLeft_q - 4'h1;
    end
endmodule : srbg_serial_partner

/* test/serial_baud_rate_generator_test.sv */
// testbench: register access, divide ratios per mode, sync clock pins, idle flag
// assumes srbg_core and the serial partner model, one 200 MHz clock
`include "srbg_cfg.svh"
module serial_baud_rate_generator_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [7:0] wrData = 8'h00;
    logic wrStrobe = 1'b0;
    logic rdStrobe = 1'b0;
    logic startRx = 1'b0;
    logic txLoad = 1'b0;
    logic [7:0] rdData;
    logic receiverIdle, txShiftEmpty, bitTick, halfTick;
    logic syncClkOut, syncClkOe, syncMode, clockMaster;
    int errCount = 0;
    int nCompared = 0;
    int cycles = 0;
    // mode table: control bytes, divisor bytes, multiplier and effective n
    logic [7:0] txTab [6] = '{8'h00, 8'h00, 8'h04, 8'h04, 8'h94, 8'h90};
    logic [7:0] rcTab [6] = '{8'h00, 8'h08, 8'h00, 8'h08, 8'h00, 8'h08};
    logic [7:0] hiTab [6] = '{8'h01, 8'h01, 8'h00, 8'h01, 8'h01, 8'h00};
    logic [7:0] loTab [6] = '{8'h02, 8'h00, 8'h05, 8'h03, 8'h03, 8'h07};
    int mTab [6] = '{64, 16, 16, 4, 4, 4};
    int nTab [6] = '{2, 256, 5, 259, 3, 7};

    always #2.5 clk_sys = ~clk_sys;

    srbg_core srbg_core_inst (.clk_sys(clk_sys), .rst(rst), .addr(addr), .wrData(wrData),
        .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
        .receiverIdle(receiverIdle), .txShiftEmpty(txShiftEmpty), .bitTick(bitTick),
        .halfTick(halfTick), .syncClkOut(syncClkOut), .syncClkOe(syncClkOe),
        .syncMode(syncMode), .clockMaster(clockMaster));

    srbg_serial_partner srbg_serial_partner_inst (.clk_sys(clk_sys), .rst(rst),
        .bitTick(bitTick), .startRx(startRx), .txLoad(txLoad),
        .receiverIdle(receiverIdle), .txShiftEmpty(txShiftEmpty));

    task wrapUp;
        $display("compared %0d mismatches %0d", nCompared, errCount);
        if (errCount == 0 && nCompared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : wrapUp

    task check(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp)
        begin
            errCount++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        wrStrobe <= 1'b1;
        addr <= a;
        wrData <= d;
        @(posedge clk_sys);
        wrStrobe <= 1'b0;
    endtask : wr

    task rdChk(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        rdStrobe <= 1'b1;
        addr <= a;
        @(posedge clk_sys);
        rdStrobe <= 1'b0;
        @(negedge clk_sys);
        check({24'h0, rdData}, {24'h0, exp});
    endtask : rdChk

    // cycles from the divisor write to the first half tick and two bit ticks
    task measure(input int m, input int n);
        int half, first, second;
        half = 0;
        first = 0;
        second = 0;
        for (int k = 1; k <= 2 * m * (n + 1) + 4; k++)
        begin
            @(negedge clk_sys);
            if (halfTick === 1'b1 && half == 0) half = k;
            if (bitTick === 1'b1 && first != 0 && second == 0) second = k;
            if (bitTick === 1'b1 && first == 0) first = k;
        end
        check(half, m / 2 * (n + 1) + 2);
        check(first, m * (n + 1) + 2);
        check(second, 2 * m * (n + 1) + 2);
    endtask : measure

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            errCount++;
            wrapUp();
        end
    end

    initial
    begin
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        rdChk(`SRBG_OFS_RATE_CTL, 8'h40);
        rdChk(`SRBG_OFS_RX_CTL, 8'h00);
        rdChk(`SRBG_OFS_DIV_LOW, 8'h00);
        rdChk(`SRBG_OFS_DIV_HIGH, 8'h00);
        rdChk(`SRBG_OFS_TX_CTL, 8'h02);
        rdChk(3'h5, 8'h00);
        @(posedge clk_sys);
        txLoad <= 1'b1;
        for (int i = 0; i < 8; i++) wr(3'(i), 8'hff);
        rdChk(`SRBG_OFS_RATE_CTL, 8'h5b);
        rdChk(`SRBG_OFS_RX_CTL, 8'hf8);
        rdChk(`SRBG_OFS_DIV_LOW, 8'hff);
        rdChk(`SRBG_OFS_DIV_HIGH, 8'hff);
        rdChk(`SRBG_OFS_TX_CTL, 8'hfd);
        rdChk(3'h6, 8'h00);
        @(posedge clk_sys);
        txLoad <= 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            wr(`SRBG_OFS_TX_CTL, txTab[i]);
            wr(`SRBG_OFS_RATE_CTL, rcTab[i]);
            wr(`SRBG_OFS_DIV_HIGH, hiTab[i]);
            wr(`SRBG_OFS_DIV_LOW, loTab[i]);
            measure(mTab[i], nTab[i]);
            check({31'h0, syncClkOe}, {31'h0, txTab[i][7] & txTab[i][4]});
            check({31'h0, clockMaster}, {31'h0, txTab[i][7]});
            check({31'h0, syncMode}, {31'h0, txTab[i][4]});
        end
        // sync slave: clock pin released, idle level from polarity
        wr(`SRBG_OFS_TX_CTL, 8'h10);
        wr(`SRBG_OFS_RATE_CTL, 8'h10);
        repeat (3) @(negedge clk_sys);
        check({31'h0, syncClkOe}, 32'h0);
        check({31'h0, clockMaster}, 32'h0);
        check({31'h0, syncClkOut}, 32'h1);
        check({31'h0, syncMode}, 32'h1);
        // reception in progress, then idle again before any rate change
        wr(`SRBG_OFS_TX_CTL, 8'h04);
        wr(`SRBG_OFS_RATE_CTL, 8'h00);
        wr(`SRBG_OFS_DIV_LOW, 8'h00);
        @(posedge clk_sys);
        startRx <= 1'b1;
        @(posedge clk_sys);
        startRx <= 1'b0;
        rdChk(`SRBG_OFS_RATE_CTL, 8'h00);
        for (int k = 0; k < 400 && receiverIdle !== 1'b1; k++) @(negedge clk_sys);
        rdChk(`SRBG_OFS_RATE_CTL, 8'h40);
        wrapUp();
    end
endmodule : serial_baud_rate_generator_test
